//--- verilog/vcs_vector_control.sv
// vector control mode supervisor with cascaded speed, torque, flux loops
`timescale 1ns/1ps
module vcs_vector_control
  import vcs_pkg::*;
#(
  parameter int W = 16,
  parameter int CNT_W = 32,
  parameter int MS_CYCLES = VCS_MS_CYCLES,
  parameter int LIMIT_WAIT_MS = VCS_LIMIT_WAIT_MS
) (
  // clock, reset and controller step
  input wire logic clk,
  input wire logic rst,
  input wire logic ctrl_step,
  // configuration
  input wire logic [7:0] control_type_select,
  input wire logic torque_control_select,
  input wire logic [W-1:0] changeover_start_frequency,
  input wire logic [7:0] changeover_hysteresis_frequency,
  input wire logic [15:0] changeover_wait_time,
  input wire logic [7:0] constant_torque_boost,
  input wire logic [7:0] acceleration_torque_boost,
  input wire logic [15:0] motor_model_control_word,
  input wire logic [3:0] encoder_type_select,
  input wire logic encoder_differential,
  // controller tuning
  input wire logic signed [W-1:0] speed_kp,
  input wire logic signed [W-1:0] speed_ki,
  input wire logic signed [W-1:0] current_kp,
  input wire logic signed [W-1:0] current_ki,
  input wire logic signed [W-1:0] torque_limit,
  input wire logic signed [W-1:0] precontrol_term,
  input wire logic signed [W-1:0] droop_term,
  // setpoints
  input wire logic signed [W-1:0] ramp_input_frequency,
  input wire logic signed [W-1:0] speed_setpoint,
  input wire logic signed [W-1:0] torque_setpoint,
  input wire logic accelerating,
  // motor model and measurements
  input wire logic signed [W-1:0] model_speed,
  input wire logic signed [W-1:0] model_flux_angle,
  input wire logic signed [W-1:0] current_flux,
  input wire logic signed [W-1:0] current_torque,
  input wire logic [W-1:0] magnetizing_current,
  input wire logic [W-1:0] rated_motor_current,
  // encoder tracks
  input wire logic track_a,
  input wire logic track_a_inverted,
  input wire logic track_b,
  input wire logic track_b_inverted,
  input wire logic signed [W-1:0] encoder_speed,
  input wire logic signed [W-1:0] encoder_flux_angle,
  // status and outputs
  output logic speed_mode,
  output logic torque_mode,
  output logic encoder_vector_mode,
  output logic sensorless_vector_mode,
  output logic closed_loop,
  output logic encoder_ok,
  output logic [1:0] encoder_tracks,
  output logic signed [W-1:0] speed_actual,
  output logic signed [W-1:0] flux_angle,
  output logic signed [W-1:0] torque_demand,
  output logic signed [W-1:0] flux_voltage,
  output logic signed [W-1:0] torque_voltage
);
  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  logic speed_next, torque_next, enc_next, sl_next;
  always_comb begin
    speed_next = 1'b0;
    torque_next = 1'b0;
    enc_next = 1'b0;
    sl_next = 1'b0;
    if (control_type_select == VCS_CODE_SL_SPEED ||
        control_type_select == VCS_CODE_ENC_SPEED) begin
      speed_next = !torque_control_select;
      torque_next = torque_control_select;
      enc_next = control_type_select == VCS_CODE_ENC_SPEED;
      sl_next = !enc_next;
    end else if (control_type_select == VCS_CODE_SL_TORQUE ||
                 control_type_select == VCS_CODE_ENC_TORQUE) begin
      torque_next = 1'b1;
      enc_next = control_type_select == VCS_CODE_ENC_TORQUE;
      sl_next = !enc_next;
    end
  end

  // ------------------------------------------------------------
  // encoder track check
  // ------------------------------------------------------------
  // differential pairs must be complementary; single-ended ignores them
  logic enc_ok_next;
  always_comb begin
    enc_ok_next = encoder_type_select == VCS_ENC_TWO_TRACK;
    if (encoder_differential &&
        ((track_a == track_a_inverted) || (track_b == track_b_inverted)))
      enc_ok_next = 1'b0;
  end

  // ------------------------------------------------------------
  // sensorless changeover supervisor
  // ------------------------------------------------------------
  logic [W+7:0] hyst_prod;
  logic [W-1:0] hyst_hz;
  logic [W-1:0] abs_set, abs_act;
  logic low_region, below_hyst, wait_done, direct_ok;
  logic [CNT_W-1:0] wait_cycles, limit_cycles;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  vcs_state_t state_reg, state_next;
  logic init_reg;

  function automatic logic [W-1:0] vcs_abs(input logic signed [W-1:0] v);
    vcs_abs = v[W-1] ? W'(-v) : W'(v);
  endfunction : vcs_abs

  always_comb begin
    hyst_prod = (W+8)'(changeover_start_frequency) *
                (W+8)'(changeover_hysteresis_frequency);
    hyst_hz = W'(hyst_prod / (W+8)'(VCS_PERCENT_FULL));
    abs_set = vcs_abs(ramp_input_frequency);
    abs_act = vcs_abs(model_speed);
    low_region = abs_act < changeover_start_frequency;
    below_hyst = (abs_set < hyst_hz) && (abs_act < hyst_hz);
    wait_cycles = CNT_W'(changeover_wait_time) * CNT_W'(MS_CYCLES);
    limit_cycles = CNT_W'(LIMIT_WAIT_MS) * CNT_W'(MS_CYCLES);
    // fall back at whichever of the two waits comes first
    wait_done = (cnt_reg >= wait_cycles) || (cnt_reg >= limit_cycles);
    direct_ok = motor_model_control_word[VCS_CTRL_WORD_DIRECT_BIT];
    cnt_next = low_region ? cnt_reg + CNT_W'(1) : '0;
    // hold at the threshold only while still near zero, else restart
    if (wait_done && low_region) cnt_next = cnt_reg;
    state_next = state_reg;
    if (init_reg) begin
      state_next = direct_ok ? VCS_CLOSED : VCS_OPEN;
    end else begin
      case (state_reg)
        VCS_CLOSED: begin
          if (below_hyst && !direct_ok) state_next = VCS_OPEN;
          else if (low_region && wait_done) state_next = VCS_OPEN;
        end
        VCS_OPEN: begin
          if (!low_region || (direct_ok && !below_hyst))
            state_next = VCS_CLOSED;
        end
        default: state_next = VCS_OPEN;
      endcase
    end
    if (!sl_next) state_next = VCS_CLOSED;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= VCS_OPEN;
      cnt_reg <= '0;
      init_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      init_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // speed actual, flux angle and open-loop current
  // ------------------------------------------------------------
  logic signed [W-1:0] spd_next, ang_next, open_iq, iq_ref;
  logic [W+7:0] boost_prod;
  logic signed [W-1:0] spd_out, iq_set, id_set;
  logic signed [W+1:0] spd_sum;
  always_comb begin
    ang_next = enc_next ? encoder_flux_angle : model_flux_angle;
    if (enc_next) spd_next = encoder_speed;
    else if (state_reg == VCS_OPEN) spd_next = speed_setpoint;
    else spd_next = model_speed;
    // boost adds rated-current share; zero boost leaves magnetizing only
    boost_prod = (W+8)'(rated_motor_current) *
                 (W+8)'(accelerating ? constant_torque_boost +
                  acceleration_torque_boost : constant_torque_boost);
    open_iq = W'(boost_prod / (W+8)'(VCS_PERCENT_FULL));
    // sum of pi and pre-control minus droop, then torque limit
    spd_sum = (W+2)'(spd_out) + (W+2)'(precontrol_term)
              - (W+2)'(droop_term);
    if (spd_sum > (W+2)'(torque_limit)) spd_sum = (W+2)'(torque_limit);
    if (spd_sum < -(W+2)'(torque_limit)) spd_sum = -(W+2)'(torque_limit);
    iq_ref = speed_next ? W'(spd_sum) : torque_setpoint;
    iq_set = (sl_next && state_reg == VCS_OPEN) ? open_iq : iq_ref;
    id_set = W'(magnetizing_current);
  end

  // ------------------------------------------------------------
  // cascaded controllers
  // ------------------------------------------------------------
  logic signed [W-1:0] vd, vq;
  vcs_pi #(.W(W)) u_speed_pi (
    .clk(clk), .rst(rst), .step(ctrl_step), .hold(!speed_next),
    .kp(speed_kp), .ki(speed_ki), .limit(torque_limit),
    .setpoint(speed_setpoint), .actual(spd_next), .out(spd_out)
  );
  vcs_pi #(.W(W)) u_flux_pi (
    .clk(clk), .rst(rst), .step(ctrl_step), .hold(1'b0),
    .kp(current_kp), .ki(current_ki), .limit(torque_limit),
    .setpoint(id_set), .actual(current_flux), .out(vd)
  );
  vcs_pi #(.W(W)) u_torque_pi (
    .clk(clk), .rst(rst), .step(ctrl_step), .hold(1'b0),
    .kp(current_kp), .ki(current_ki), .limit(torque_limit),
    .setpoint(iq_set), .actual(current_torque), .out(vq)
  );

  // ------------------------------------------------------------
  // output registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      speed_mode <= 1'b0;
      torque_mode <= 1'b0;
      encoder_vector_mode <= 1'b0;
      sensorless_vector_mode <= 1'b0;
      closed_loop <= 1'b0;
      encoder_ok <= 1'b0;
      encoder_tracks <= 2'h0;
      speed_actual <= '0;
      flux_angle <= '0;
      torque_demand <= '0;
      flux_voltage <= '0;
      torque_voltage <= '0;
    end else begin
      speed_mode <= speed_next;
      torque_mode <= torque_next;
      encoder_vector_mode <= enc_next;
      sensorless_vector_mode <= sl_next;
      closed_loop <= state_next == VCS_CLOSED;
      encoder_ok <= enc_ok_next;
      encoder_tracks <= {track_b, track_a};
      speed_actual <= spd_next;
      flux_angle <= ang_next;
      torque_demand <= iq_set;
      flux_voltage <= vd;
      torque_voltage <= vq;
    end
  end
endmodule : vcs_vector_control

//--- shared/vcs_pkg.sv
// constants and types for the vector control mode supervisor
//
// How it works
// - code 20/21 with torque select 0: speed control, sensorless or encoder
// - code 22, 23, or 20/21 with torque select 1 gives torque control
// - in speed mode, outside sensorless open loop, the speed loop output feeds the torque loop
// - stator current split into flux and torque parts, each with a PI
// - without encoder, flux position comes from the motor model, speed too in closed loop
// - sensorless changeover uses a time and a frequency condition
// - setpoint and actual both below hysteresis: change over at once
// - hysteresis hertz equals start frequency times percentage over 100
// - in open loop the speed actual value is the speed setpoint
// - zero boost impresses only magnetizing current scaled to rated current
// - staying near zero longer than 2 s or wait time forces open loop
// - start frequency sets the lower limit of sensorless closed loop
// - a control word bit allows closed-loop start and reversing at zero
// - encoder type 2 selects two tracks, single-ended or differential
// - shared speed controller sums PI and pre-control, minus droop; torque limit
package vcs_pkg;
  localparam logic [7:0] VCS_CODE_SL_SPEED = 8'h14;
  localparam logic [7:0] VCS_CODE_ENC_SPEED = 8'h15;
  localparam logic [7:0] VCS_CODE_SL_TORQUE = 8'h16;
  localparam logic [7:0] VCS_CODE_ENC_TORQUE = 8'h17;
  localparam logic [3:0] VCS_ENC_TWO_TRACK = 4'h2;
  localparam int VCS_PERCENT_FULL = 100;
  localparam int VCS_CLK_HZ = 25000000;
  localparam int VCS_MS_CYCLES = VCS_CLK_HZ / 1000;
  localparam int VCS_LIMIT_WAIT_MS = 2000;
  localparam int VCS_CTRL_WORD_DIRECT_BIT = 0;
  localparam int VCS_PI_SHIFT = 4;
  typedef enum logic [1:0] {
    VCS_OPEN = 2'b01,
    VCS_CLOSED = 2'b10
  } vcs_state_t;
endpackage : vcs_pkg

//--- verilog/vcs_pi.sv
// saturating pi controller, one step per enable pulse
`timescale 1ns/1ps
module vcs_pi
  import vcs_pkg::*;
#(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic step,
  input wire logic hold,
  input wire logic signed [W-1:0] kp,
  input wire logic signed [W-1:0] ki,
  input wire logic signed [W-1:0] limit,
  // loop signals
  input wire logic signed [W-1:0] setpoint,
  input wire logic signed [W-1:0] actual,
  output logic signed [W-1:0] out
);
  localparam int AW = 2 * W + 2;
  logic signed [AW-1:0] integ_reg, integ_next;
  logic signed [AW-1:0] err, sum, lim_w;
  logic signed [W-1:0] out_next;

  always_comb begin
    err = AW'(setpoint) - AW'(actual);
    lim_w = AW'(limit) <<< VCS_PI_SHIFT;
    integ_next = integ_reg;
    if (hold) begin
      integ_next = '0;
    end else if (step) begin
      integ_next = integ_reg + err * AW'(ki);
      if (integ_next > lim_w) integ_next = lim_w;
      if (integ_next < -lim_w) integ_next = -lim_w;
    end
    sum = ((err * AW'(kp)) + integ_next) >>> VCS_PI_SHIFT;
    if (sum > AW'(limit)) sum = AW'(limit);
    if (sum < -AW'(limit)) sum = -AW'(limit);
    out_next = W'(sum);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      integ_reg <= '0;
      out <= '0;
    end else begin
      integ_reg <= integ_next;
      out <= out_next;
    end
  end
endmodule : vcs_pi

//--- sim/vcs_vector_control_asserts.sv
// concurrent checks on the ports of the vector control supervisor
`timescale 1ns/1ps
module vcs_vector_control_asserts
  import vcs_pkg::*;
(
  // watched ports
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] control_type_select,
  input wire logic torque_control_select,
  input wire logic [3:0] encoder_type_select,
  input wire logic speed_mode,
  input wire logic torque_mode,
  input wire logic encoder_vector_mode,
  input wire logic sensorless_vector_mode,
  input wire logic closed_loop,
  input wire logic encoder_ok
);
  // up_reg counts edges since reset so $past never sees reset values
  logic [1:0] up_reg;
  logic [1:0] up_next;
  logic v, sp, tq;
  always_comb begin
    up_next = (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) up_reg <= 2'h0;
    else up_reg <= up_next;
  end
  assign v = control_type_select[7:2] == 6'h05;
  assign sp = v && !control_type_select[1] && !torque_control_select;
  assign tq = v && (control_type_select[1] || torque_control_select);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_SPEED_DECODE: assert property (up_reg != 2'h0 |->
    speed_mode == $past(sp)) else $error("speed mode decode");
  AST_TORQUE_DECODE: assert property (up_reg != 2'h0 |->
    torque_mode == $past(tq)) else $error("torque mode decode");
  AST_ENC_DECODE: assert property (up_reg != 2'h0 |->
    encoder_vector_mode == $past(v && control_type_select[0]))
    else $error("encoder mode decode");
  AST_SENSORLESS_DECODE: assert property (up_reg != 2'h0 |->
    sensorless_vector_mode == $past(v && !control_type_select[0]))
    else $error("sensorless mode decode");
  AST_ONE_LOOP: assert property (!(speed_mode && torque_mode))
    else $error("speed and torque mode together");
  AST_ONE_SOURCE: assert property (!(encoder_vector_mode &&
    sensorless_vector_mode)) else $error("two speed sources");
  AST_ENC_CLOSED: assert property ((up_reg == 2'h3 &&
    encoder_vector_mode) [*3] |-> closed_loop)
    else $error("encoder mode left closed loop");
  AST_ENC_TYPE: assert property (up_reg != 2'h0 &&
    $past(encoder_type_select) != VCS_ENC_TWO_TRACK |-> !encoder_ok)
    else $error("encoder ok with wrong type");
  cover property (speed_mode && sensorless_vector_mode);
  cover property (torque_mode && encoder_vector_mode);
  cover property ($fell(closed_loop));
endmodule : vcs_vector_control_asserts
bind vcs_vector_control vcs_vector_control_asserts u_chk (
  .clk(clk), .rst(rst), .control_type_select(control_type_select),
  .torque_control_select(torque_control_select),
  .encoder_type_select(encoder_type_select), .speed_mode(speed_mode),
  .torque_mode(torque_mode), .encoder_vector_mode(encoder_vector_mode),
  .sensorless_vector_mode(sensorless_vector_mode),
  .closed_loop(closed_loop), .encoder_ok(encoder_ok)
);

//--- sim/vcs_motor.sv
// induction motor with two-track encoder, far side of the supervisor
`timescale 1ns/1ps
module vcs_motor
  import vcs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // shaft speed set by the bench, drive voltages
  input wire logic signed [15:0] shaft_speed,
  input wire logic signed [15:0] flux_voltage,
  input wire logic signed [15:0] torque_voltage,
  // fault injection: inverted track a no longer complementary
  input wire logic pair_fault,
  // measurements and encoder tracks
  output logic signed [15:0] model_speed,
  output logic signed [15:0] current_flux,
  output logic signed [15:0] current_torque,
  output logic track_a,
  output logic track_a_inverted,
  output logic track_b,
  output logic track_b_inverted
);
  logic [1:0] ph_reg;
  logic [1:0] ph_next;
  always_comb begin
    ph_next = ph_reg + ((shaft_speed != 16'h0000) ? 2'h1 : 2'h0);
  end
  // currents lag the voltages by a cycle, a crude winding
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {ph_reg, current_flux, current_torque} <= '0;
    end else begin
      {ph_reg, current_flux, current_torque} <=
        {ph_next, flux_voltage, torque_voltage};
    end
  end
  // gray phase keeps the tracks a quarter period apart
  assign track_a = ph_reg[1];
  assign track_b = ph_reg[1] ^ ph_reg[0];
  assign track_a_inverted = pair_fault ? track_a : ~track_a;
  assign track_b_inverted = ~track_b;
  assign model_speed = shaft_speed;
endmodule : vcs_motor

//--- sim/testbench.sv
// testbench for the vector control mode supervisor
`timescale 1ns/1ps
module testbench;
  import vcs_pkg::*;
  logic clk = 1'b0;
  logic rst, ctrl_step, torque_control_select, accelerating;
  logic encoder_differential, track_a, track_a_inverted, track_b;
  logic track_b_inverted, speed_mode, torque_mode, encoder_vector_mode;
  logic sensorless_vector_mode, closed_loop, encoder_ok;
  logic [1:0] encoder_tracks;
  logic pair_fault;
  logic [3:0] encoder_type_select;
  logic [7:0] control_type_select, changeover_hysteresis_frequency;
  logic [7:0] constant_torque_boost, acceleration_torque_boost;
  logic [15:0] changeover_start_frequency, changeover_wait_time;
  logic [15:0] motor_model_control_word, magnetizing_current;
  logic [15:0] rated_motor_current;
  logic signed [15:0] speed_kp, speed_ki, current_kp, current_ki;
  logic signed [15:0] torque_limit, precontrol_term, droop_term;
  logic signed [15:0] ramp_input_frequency, speed_setpoint, shaft_speed;
  logic signed [15:0] torque_setpoint, model_speed, model_flux_angle;
  logic signed [15:0] current_flux, current_torque, encoder_speed;
  logic signed [15:0] encoder_flux_angle, speed_actual, flux_angle;
  logic signed [15:0] torque_demand, flux_voltage, torque_voltage;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  // short ms and a 5 ms limit in place of 2 s so the wait and the limit fit in a short run
  vcs_vector_control #(.MS_CYCLES(10), .LIMIT_WAIT_MS(5)) dut (.*);
  vcs_motor motor (.*);
  always #20 clk = ~clk;
  always @(negedge clk) ctrl_step <= ~ctrl_step;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask : tick
  task automatic set_spd(input logic [15:0] s);
    {shaft_speed, speed_setpoint, ramp_input_frequency} = {3{s}};
    encoder_speed = s;
  endtask : set_spd
  task automatic wait_cl(input logic lv, input int lim, output int k);
    k = 0;
    while (closed_loop !== lv && k < lim) begin
      tick(1);
      k++;
    end
  endtask : wait_cl
  task automatic do_reset;
    rst = 1'b1;
    tick(6);
    rst = 1'b0;
  endtask : do_reset
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] c;
    logic [1:0] t;
    int n;
    {rst, ctrl_step, torque_control_select} = 3'h4;
    {accelerating, encoder_differential, encoder_type_select} = 6'h02;
    pair_fault = 1'b0;
    {speed_kp, speed_ki, current_kp, current_ki} = {4{16'sh0010}};
    {torque_limit, precontrol_term, droop_term} = 48'h0400_0002_0001;
    {torque_setpoint, model_flux_angle, encoder_flux_angle} = 48'h20_0100_0200;
    {magnetizing_current, rated_motor_current} = 32'h0040_00c8;
    {control_type_select, changeover_hysteresis_frequency} = 16'h1432;
    {constant_torque_boost, acceleration_torque_boost} = 16'h320a;
    changeover_start_frequency = 16'h000a;
    {changeover_wait_time, motor_model_control_word} = 32'h0003_0000;
    set_spd(16'h0003);
    do_reset();
    tick(3);
    chk(closed_loop, 16'h0000);
    chk(speed_actual, 16'h0003);
    chk(torque_demand, 16'h0064);
    chk(flux_angle, 16'h0100);
    // gains 0x10 over shift 4: p term equals the error, first step doubles it
    chk(flux_voltage, 16'h0080);
    chk(torque_voltage, 16'h00c8);
    constant_torque_boost = 8'h00;
    tick(3);
    chk(torque_demand, 16'h0000);
    accelerating = 1'b1;
    tick(3);
    chk(torque_demand, 16'h0014);
    accelerating = 1'b0;
    for (int i = 0; i < 10; i++) begin
      c = 8'h13 + 8'(i / 2);
      {control_type_select, torque_control_select} = {c, i[0]};
      tick(2);
      chk(speed_mode, (c inside {8'h14, 8'h15}) && !i[0]);
      chk(torque_mode, c > 8'h15 || (c > 8'h13 && i[0]));
      chk(encoder_vector_mode, c == 8'h15 || c == 8'h17);
      chk(sensorless_vector_mode, c == 8'h14 || c == 8'h16);
    end
    chk(torque_demand, 16'h0020);
    {control_type_select, torque_control_select} = 9'h028;
    // no speed gains: the speed loop output is pre-control minus droop
    {speed_kp, speed_ki} = 32'h0000_0000;
    for (int j = 0; j < 2; j++) begin
      changeover_wait_time = j ? 16'h0fff : 16'h0003;
      set_spd(16'h0014);
      // one edge out of the low region so the wait counter restarts
      tick(1);
      wait_cl(1'b1, 20, n);
      chk(closed_loop, 16'h0001);
      set_spd(16'h0008);
      wait_cl(1'b0, 80, n);
      chk(n >= (j ? 49 : 29) && n <= (j ? 54 : 34), 1'b1);
    end
    set_spd(16'h0014);
    wait_cl(1'b1, 20, n);
    set_spd(16'h0006);
    tick(10);
    chk(closed_loop, 16'h0001);
    chk(torque_demand, 16'h0001);
    set_spd(16'h0004);
    wait_cl(1'b0, 10, n);
    chk(n <= 3, 1'b1);
    motor_model_control_word = 16'h0001;
    do_reset();
    tick(3);
    chk(closed_loop, 16'h0001);
    control_type_select = 8'h15;
    tick(3);
    chk(encoder_ok, 16'h0001);
    chk(flux_angle, 16'h0200);
    chk(speed_actual, 16'h0004);
    for (int k = 0; k < 4; k++) begin
      t = {track_b, track_a};
      tick(1);
      chk(encoder_tracks, t);
    end
    encoder_differential = 1'b1;
    tick(3);
    chk(encoder_ok, 16'h0001);
    pair_fault = 1'b1;
    tick(3);
    chk(encoder_ok, 16'h0000);
    pair_fault = 1'b0;
    encoder_type_select = 4'h3;
    tick(3);
    chk(encoder_ok, 16'h0000);
    final_report();
  end
endmodule : testbench
